// File: src/bft_pkg.sv
`default_nettype none
package bft_pkg;

	// operating criterion encodings
	typedef enum logic [1:0] {
		BFT_MODE_CUR = 2'h0,
		BFT_MODE_CUR_AND_DO = 2'h1,
		BFT_MODE_CUR_OR_DO = 2'h2,
		BFT_MODE_DO = 2'h3
	} bft_mode_e;

	// residual source select
	typedef enum logic [1:0] {
		BFT_RES_OFF = 2'h0,
		BFT_RES_CH1 = 2'h1,
		BFT_RES_CH2 = 2'h2,
		BFT_RES_CALC = 2'h3
	} bft_res_e;

	// status codes shown to software
	typedef enum logic [2:0] {
		BFT_ST_NORMAL = 3'h0,
		BFT_ST_START = 3'h1,
		BFT_ST_RETRIP = 3'h2,
		BFT_ST_FAIL = 3'h3,
		BFT_ST_BLOCKED = 3'h4
	} bft_status_e;

	// register offsets (word addresses, one per register)
	localparam logic [3:0] BFT_REG_CTRL = 4'h0;
	localparam logic [3:0] BFT_REG_PH_LVL = 4'h1;
	localparam logic [3:0] BFT_REG_RES_LVL = 4'h2;
	localparam logic [3:0] BFT_REG_RT_DLY = 4'h3;
	localparam logic [3:0] BFT_REG_BF_DLY = 4'h4;
	localparam logic [3:0] BFT_REG_STATUS = 4'h5;
	localparam logic [3:0] BFT_REG_TICK = 4'h6;

	// control word fields
	localparam int BFT_CTRL_MODE_LSB = 0;
	localparam int BFT_CTRL_RES_LSB = 2;
	localparam int BFT_CTRL_RT_EN_BIT = 4;

	// reset values
	localparam logic [1:0] BFT_RST_MODE = 2'h0;
	localparam logic [1:0] BFT_RST_RES = 2'h0;
	localparam logic BFT_RST_RT_EN = 1'b1;
	localparam logic [15:0] BFT_RST_PH_LVL = 16'h00C8;
	localparam logic [15:0] BFT_RST_RES_LVL = 16'h04B0;

	// delays are counted in 5 ms steps
	localparam int BFT_STEP_MS = 5;
	localparam int BFT_RT_DLY_MS = 100;
	localparam int BFT_BF_DLY_MS = 200;
	localparam logic [15:0] BFT_RST_RT_DLY = 16'(BFT_RT_DLY_MS / BFT_STEP_MS);
	localparam logic [15:0] BFT_RST_BF_DLY = 16'(BFT_BF_DLY_MS / BFT_STEP_MS);

	// program cycle period
	localparam int BFT_CLK_MHZ = 100;
	localparam int BFT_CYCLE_CLKS = BFT_STEP_MS * 1000 * BFT_CLK_MHZ;

	// hysteresis: release below 97/100 of threshold
	localparam int BFT_HYST_NUM = 97;
	localparam int BFT_HYST_DEN = 100;

endpackage

`default_nettype wire

// File: src/bft_cmp_if.sv
`timescale 1ns/1ps
`default_nettype none
// current comparator results handed to the supervisor
interface bft_cmp_if;
	logic ph_pick;
	logic res_pick;
	modport drv (output ph_pick, output res_pick);
	modport use_ (input ph_pick, input res_pick);
endinterface
`default_nettype wire

// File: src/bft_pickup.sv
`timescale 1ns/1ps
`default_nettype none
// current pick-up comparators with 97 % release hysteresis
module bft_pickup #(
	parameter int W = 16
) (
	// clock and reset
	input wire logic mclk,
	input wire logic sys_rst,
	// refresh strobe and inputs
	input wire logic tick,
	input wire logic [W-1:0] ph_a,
	input wire logic [W-1:0] ph_b,
	input wire logic [W-1:0] ph_c,
	input wire logic [W-1:0] res_cur,
	input wire logic res_used,
	input wire logic [W-1:0] ph_lvl,
	input wire logic [W-1:0] res_lvl,
	// results
	bft_cmp_if.drv cmp
);
	import bft_pkg::*;

	typedef struct packed {
		logic ph;
		logic res;
	} bft_pu_s;

	bft_pu_s st;
	bft_pu_s next_st;

	// compare scaled so the 97 % drop needs no divider
	function automatic logic pick(input logic [W-1:0] m,
		input logic [W-1:0] lvl, input logic held);
		logic [W+7:0] ms;
		logic [W+7:0] ls;
		ms = (W+8)'(m) * (W+8)'(BFT_HYST_DEN);
		ls = (W+8)'(lvl) * (W+8)'(BFT_HYST_NUM);
		if (held)
			pick = ms >= ls;
		else
			pick = m > lvl;
	endfunction

	always_comb
	begin
		next_st = st;
		if (tick)
		begin
			next_st.ph = pick(ph_a, ph_lvl, st.ph) |
				pick(ph_b, ph_lvl, st.ph) | pick(ph_c, ph_lvl, st.ph);
			next_st.res = res_used & pick(res_cur, res_lvl, st.res);
		end
	end

	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
			st <= '0;
		else
			st <= next_st;
	end

	assign cmp.ph_pick = st.ph;
	assign cmp.res_pick = st.res;
endmodule // bft_pickup
`default_nettype wire

// File: src/breaker_failure_timer.sv
// Added by the designer: the register addresses and the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
// Function
// - status reads normal, start, retrip, failure, blocked
// - blocking sampled at start of each cycle
// - unblocked pick-up raises start and timers
// - blocked pick-up shows blocked, no outputs
// - late blocking clears start like pick-up drop
// - one pick-up starts both independent timers
// - retrip enable gates retrip output
// - retrip after retrip delay, 5 ms steps
// - failure output after failure delay
// - any phase or the selected residual over threshold
// - current mode ignores trip, resets on drop
// - and-mode holds timers until trip asserts
// - and-mode resets when either drops
// - or-mode starts on either condition
// - or-mode resets only when both gone
// - retrip and failure outputs kept separate
// - pick-up releases below 97 percent
// - criterion selectable, current-only default
// - current comparison refreshed every 5 ms
module breaker_failure_timer #(
	parameter int CUR_W = 16,
	parameter int CYCLE_CLKS = bft_pkg::BFT_CYCLE_CLKS
) (
	// clock and reset
	input wire logic mclk,
	input wire logic sys_rst,
	// avalon-mm slave
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// measured magnitudes
	input wire logic [CUR_W-1:0] ph_a_mag,
	input wire logic [CUR_W-1:0] ph_b_mag,
	input wire logic [CUR_W-1:0] ph_c_mag,
	input wire logic [CUR_W-1:0] res_ch1_mag,
	input wire logic [CUR_W-1:0] res_ch2_mag,
	input wire logic [CUR_W-1:0] res_calc_mag,
	// pins from outside
	input wire logic block_in,
	input wire logic primary_trip,
	// outputs to breaker coils, then start and blocked flags
	output logic redundant_trip,
	output logic breaker_failure_output,
	output logic start_out,
	output logic blocked_out
);
	import bft_pkg::*;

	typedef struct packed {
		logic [2:0] blk_sync;
		logic [2:0] trip_sync;
		logic blk_q;
		logic trip_q;
		logic [31:0] clk_cnt;
		logic tick;
		logic blk_cycle;
		bft_mode_e mode;
		bft_res_e res_sel;
		logic rt_en;
		logic [CUR_W-1:0] ph_lvl;
		logic [CUR_W-1:0] residual_pickup_level;
		logic [15:0] redundant_trip_delay;
		logic [15:0] fail_delay;
		logic [15:0] rt_cnt;
		logic [15:0] bf_cnt;
		logic started;
		logic blocked;
		logic retrip;
		logic fail;
		logic [31:0] tick_count;
		logic ack;
		logic [31:0] rdata;
	} bft_s;

	bft_s st;
	bft_s next_st;
	bft_cmp_if cmp ();
	logic [CUR_W-1:0] res_mag;
	logic cur_pick;
	logic crit;
	logic tick_due;

	// last clock of the cycle: pick-up and block latch on one edge
	assign tick_due = st.clk_cnt == 32'(CYCLE_CLKS - 1);

	always_comb
	begin
		unique case (st.res_sel)
			BFT_RES_CH1: res_mag = res_ch1_mag;
			BFT_RES_CH2: res_mag = res_ch2_mag;
			BFT_RES_CALC: res_mag = res_calc_mag;
			BFT_RES_OFF: res_mag = '0;
		endcase
	end

	bft_pickup #(
		.W(CUR_W)
	) u_pickup (
		.mclk(mclk),
		.sys_rst(sys_rst),
		.tick(tick_due),
		.ph_a(ph_a_mag),
		.ph_b(ph_b_mag),
		.ph_c(ph_c_mag),
		.res_cur(res_mag),
		.res_used(st.res_sel != BFT_RES_OFF),
		.ph_lvl(st.ph_lvl),
		.res_lvl(st.residual_pickup_level),
		.cmp(cmp)
	);

	assign cur_pick = cmp.ph_pick | cmp.res_pick;

	always_comb
	begin
		unique case (st.mode)
			BFT_MODE_CUR: crit = cur_pick;
			BFT_MODE_CUR_AND_DO: crit = cur_pick & st.trip_q;
			BFT_MODE_CUR_OR_DO: crit = cur_pick | st.trip_q;
			BFT_MODE_DO: crit = st.trip_q;
		endcase
	end

	// timers stop at full scale instead of wrapping back to zero
	function automatic logic [15:0] sat_inc(input logic [15:0] v);
		if (v == 16'hFFFF)
			sat_inc = v;
		else
			sat_inc = v + 16'h1;
	endfunction

	function automatic logic expired(input logic [15:0] cnt,
		input logic [15:0] dly);
		expired = cnt >= dly;
	endfunction

	function automatic logic [31:0] status_word(input bft_s s);
		bft_status_e c;
		if (s.blocked)
			c = BFT_ST_BLOCKED;
		else if (s.fail)
			c = BFT_ST_FAIL;
		else if (s.retrip)
			c = BFT_ST_RETRIP;
		else if (s.started)
			c = BFT_ST_START;
		else
			c = BFT_ST_NORMAL;
		status_word = {29'h0, c};
	endfunction

	always_comb
	begin
		next_st = st;
		next_st.ack = 1'b0;
		// pins pass three flops; act when last two agree
		next_st.blk_sync = {st.blk_sync[1:0], block_in};
		next_st.trip_sync = {st.trip_sync[1:0], primary_trip};
		if (st.blk_sync[1] == st.blk_sync[2])
			next_st.blk_q = st.blk_sync[2];
		if (st.trip_sync[1] == st.trip_sync[2])
			next_st.trip_q = st.trip_sync[2];
		next_st.tick = 1'b0;
		if (tick_due)
		begin
			next_st.clk_cnt = '0;
			next_st.tick = 1'b1;
		end
		else
			next_st.clk_cnt = st.clk_cnt + 32'h1;
		if (tick_due)
			next_st.blk_cycle = st.blk_q;
		if (st.tick)
		begin
			next_st.tick_count = st.tick_count + 32'h1;
			if (crit && st.blk_cycle)
			begin
				next_st.blocked = 1'b1;
				next_st.started = 1'b0;
				next_st.retrip = 1'b0;
				next_st.fail = 1'b0;
				next_st.rt_cnt = '0;
				next_st.bf_cnt = '0;
			end
			else if (crit)
			begin
				next_st.blocked = 1'b0;
				next_st.started = 1'b1;
				next_st.rt_cnt = sat_inc(st.rt_cnt);
				next_st.bf_cnt = sat_inc(st.bf_cnt);
				if (st.rt_en &&
					expired(next_st.rt_cnt, st.redundant_trip_delay))
					next_st.retrip = 1'b1;
				if (expired(next_st.bf_cnt, st.fail_delay))
					next_st.fail = 1'b1;
			end
			else
			begin
				next_st.blocked = st.blk_cycle & st.blocked;
				next_st.started = 1'b0;
				next_st.retrip = 1'b0;
				next_st.fail = 1'b0;
				next_st.rt_cnt = '0;
				next_st.bf_cnt = '0;
			end
		end
		if (!next_st.rt_en)
			next_st.retrip = 1'b0;
		// single-cycle bus answer
		if ((avs_read || avs_write) && !st.ack)
		begin
			next_st.ack = 1'b1;
			next_st.rdata = '0;
			if (avs_write)
			begin
				unique case (avs_address)
					BFT_REG_CTRL:
					begin
						next_st.mode = bft_mode_e'(avs_writedata[
							BFT_CTRL_MODE_LSB +: 2]);
						next_st.res_sel = bft_res_e'(avs_writedata[
							BFT_CTRL_RES_LSB +: 2]);
						next_st.rt_en = avs_writedata[BFT_CTRL_RT_EN_BIT];
					end
					BFT_REG_PH_LVL: next_st.ph_lvl = avs_writedata[CUR_W-1:0];
					BFT_REG_RES_LVL:
						next_st.residual_pickup_level =
							avs_writedata[CUR_W-1:0];
					BFT_REG_RT_DLY:
						next_st.redundant_trip_delay = avs_writedata[15:0];
					BFT_REG_BF_DLY: next_st.fail_delay = avs_writedata[15:0];
					default: ;
				endcase
			end
			else
			begin
				unique case (avs_address)
					BFT_REG_CTRL:
					begin
						next_st.rdata[BFT_CTRL_MODE_LSB +: 2] = st.mode;
						next_st.rdata[BFT_CTRL_RES_LSB +: 2] = st.res_sel;
						next_st.rdata[BFT_CTRL_RT_EN_BIT] = st.rt_en;
					end
					BFT_REG_PH_LVL: next_st.rdata = 32'(st.ph_lvl);
					BFT_REG_RES_LVL:
						next_st.rdata = 32'(st.residual_pickup_level);
					BFT_REG_RT_DLY:
						next_st.rdata = {16'h0, st.redundant_trip_delay};
					BFT_REG_BF_DLY: next_st.rdata = {16'h0, st.fail_delay};
					BFT_REG_STATUS: next_st.rdata = status_word(st);
					BFT_REG_TICK: next_st.rdata = st.tick_count;
					default: next_st.rdata = '0;
				endcase
			end
		end
	end

	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			st <= '0;
			st.mode <= bft_mode_e'(BFT_RST_MODE);
			st.res_sel <= bft_res_e'(BFT_RST_RES);
			st.rt_en <= BFT_RST_RT_EN;
			st.ph_lvl <= CUR_W'(BFT_RST_PH_LVL);
			st.residual_pickup_level <= CUR_W'(BFT_RST_RES_LVL);
			st.redundant_trip_delay <= BFT_RST_RT_DLY;
			st.fail_delay <= BFT_RST_BF_DLY;
		end
		else
			st <= next_st;
	end

	// request held until the acknowledging edge
	assign avs_waitrequest = (avs_read | avs_write) & ~st.ack;
	assign avs_readdata = st.rdata;
	assign redundant_trip = st.retrip;
	assign breaker_failure_output = st.fail;
	assign start_out = st.started;
	assign blocked_out = st.blocked;
endmodule // breaker_failure_timer
`default_nettype wire

// File: tb/bft_checker.sv
`timescale 1ns/1ps
`default_nettype none
module bft_checker (
	// clock and reset
	input wire logic mclk,
	input wire logic sys_rst,
	// bus
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic avs_waitrequest,
	// outputs
	input wire logic redundant_trip,
	input wire logic breaker_failure_output,
	input wire logic start_out,
	input wire logic blocked_out
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (sys_rst);
	wire logic rq;
	assign rq = avs_read | avs_write;
	bus_wait_a: assert property ($rose(rq) |->
		avs_waitrequest ##1 !avs_waitrequest)
		else $error("bus answer late");
	bus_idle_a: assert property (!rq |-> !avs_waitrequest)
		else $error("wait without request");
	blk_quiet_a: assert property (blocked_out |->
		!redundant_trip && !breaker_failure_output)
		else $error("output while blocked");
	blk_nostart_a: assert property (blocked_out |-> !start_out)
		else $error("start while blocked");
	rt_start_a: assert property (redundant_trip |-> start_out)
		else $error("retrip without start");
	bf_start_a: assert property (breaker_failure_output |-> start_out)
		else $error("failure without start");
	drop_clear_a: assert property ($fell(start_out) |->
		!redundant_trip && !breaker_failure_output)
		else $error("outputs kept after drop");
	bf_hold_a: assert property ($rose(breaker_failure_output) |=>
		breaker_failure_output[*8])
		else $error("failure output glitch");
	cover property ($rose(redundant_trip));
	cover property ($rose(breaker_failure_output));
	cover property ($rose(blocked_out));
endmodule // bft_checker
`default_nettype wire

// File: tb/bft_trip_model.sv
`timescale 1ns/1ps
`default_nettype none
module bft_trip_model (
	// clock and reset
	input wire logic mclk,
	input wire logic sys_rst,
	// bench command, answer lag in clocks
	input wire logic trip_cmd,
	input wire logic [7:0] lag,
	// primary protection trip output
	output logic primary_trip
);
	logic [7:0] cnt;
	// slow answers keep pin sync off the tick
	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			cnt <= 8'h00;
			primary_trip <= 1'b0;
		end
		else
		begin
			cnt <= (trip_cmd != primary_trip) ? cnt + 8'h01 : 8'h00;
			if (trip_cmd != primary_trip && cnt >= lag)
				primary_trip <= trip_cmd;
		end
	end
endmodule // bft_trip_model
`default_nettype wire

// File: tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
`define C(n, e, g) begin n_tests++; if ((g) !== (e)) begin err_count++; \
	$display("[ERR] %s exp %0h got %0h", n, e, g); end end
module tb;
	import bft_pkg::*;
	localparam int CYC = 50;
	localparam int RT = 2;
	localparam int BF = 4;
	logic mclk = 1'b0;
	logic sys_rst = 1'b1;
	logic [3:0] avs_address = 4'h0;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata, d;
	logic avs_waitrequest, primary_trip, redundant_trip;
	logic breaker_failure_output, start_out, blocked_out;
	logic [15:0] pa = 16'h0, pb = 16'h0, pc = 16'h0, r1 = 16'h0;
	logic [15:0] r2 = 16'h0, r3 = 16'h0;
	logic [31:0] tcnt = 32'h0;
	logic block_in = 1'b0;
	logic trip_cmd = 1'b0;
	logic [7:0] lag = 8'h00;
	int err_count = 0, n_tests = 0, seed = 98, cyc = 0, t0 = 0;
	always #5 mclk = ~mclk;
	always @(posedge mclk) cyc <= cyc + 1;
	breaker_failure_timer #(.CUR_W(16), .CYCLE_CLKS(CYC)) dut (.mclk, .sys_rst,
		.avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
		.avs_waitrequest, .ph_a_mag(pa), .ph_b_mag(pb), .ph_c_mag(pc),
		.res_ch1_mag(r1), .res_ch2_mag(r2), .res_calc_mag(r3),
		.block_in, .primary_trip, .redundant_trip, .breaker_failure_output,
		.start_out, .blocked_out);
	bft_trip_model ptn (.mclk, .sys_rst, .trip_cmd, .lag, .primary_trip);
	task automatic tk(input int n);
		repeat (n) @(posedge mclk);
	endtask
	task automatic bus(input logic w, input logic [3:0] a,
		input logic [31:0] wd);
		avs_address <= a;
		avs_writedata <= wd;
		avs_write <= w;
		avs_read <= !w;
		@(posedge mclk);
		while (avs_waitrequest) @(posedge mclk);
		d = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge mclk);
	endtask
	task automatic rc(input logic [3:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		`C("reg", e, d)
	endtask
	task automatic setc(input int k, input logic [15:0] v);
		pa <= (k == 0) ? v : 16'h0010;
		pb <= (k == 1) ? v : 16'h0010;
		pc <= (k == 2) ? v : 16'h0010;
	endtask
	function automatic logic [31:0] exp_st(input logic rt, input logic bf);
		if (bf)
			return 32'(BFT_ST_FAIL);
		if (rt)
			return 32'(BFT_ST_RETRIP);
		return 32'(BFT_ST_START);
	endfunction
	function automatic logic [15:0] pct(input int p);
		return 16'(int'(BFT_RST_PH_LVL) * p / 100);
	endfunction
	task automatic wst();
		int i;
		i = 0;
		while (start_out !== 1'b1 && i < 3 * CYC)
		begin
			i++;
			@(posedge mclk);
		end
		`C("start", 1'b1, start_out)
	endtask
	task automatic mid();
		while ((cyc - t0) % CYC != CYC / 2) @(posedge mclk);
	endtask
	task automatic timing(input int lead, input logic rt_e);
		tk(lead + (RT - 1) * CYC - 5);
		`C("rt early", 1'b0, redundant_trip)
		tk(10);
		`C("rt", rt_e, redundant_trip)
		rc(BFT_REG_STATUS, exp_st(rt_e, 1'b0));
		tk((BF - RT) * CYC - 10);
		`C("bf early", 1'b0, breaker_failure_output)
		tk(10);
		`C("bf", 1'b1, breaker_failure_output)
	endtask
	task automatic wrap_up();
		$display("checks %0d errors %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial
	begin
		tk(20);
		sys_rst <= 1'b0;
		tk(2);
		rc(BFT_REG_CTRL, 32'h10);
		rc(BFT_REG_PH_LVL, 32'(BFT_RST_PH_LVL));
		rc(BFT_REG_RES_LVL, 32'(BFT_RST_RES_LVL));
		rc(BFT_REG_RT_DLY, 32'(BFT_RST_RT_DLY));
		rc(BFT_REG_BF_DLY, 32'(BFT_RST_BF_DLY));
		rc(BFT_REG_STATUS, 32'(BFT_ST_NORMAL));
		bus(1'b1, 4'h7, 32'hFFFF);
		rc(4'h7, 32'h0);
		bus(1'b1, BFT_REG_RT_DLY, RT);
		bus(1'b1, BFT_REG_BF_DLY, BF);
		trip_cmd <= 1'b1;
		lag <= 8'($random(seed) & 15);
		setc(($random(seed) & 3) % 3, 16'h00C9 + 16'($random(seed) & 255));
		wst();
		t0 = cyc;
		timing(0, 1'b1);
		rc(BFT_REG_STATUS, exp_st(1'b1, 1'b1));
		setc(0, pct(98));
		tk(2 * CYC);
		`C("hyst", 1'b1, start_out)
		setc(0, pct(96));
		tk(2 * CYC);
		`C("drop", 1'b0, start_out)
		`C("bf clr", 1'b0, breaker_failure_output)
		trip_cmd <= 1'b0;
		bus(1'b1, BFT_REG_CTRL, 32'h04);
		r1 <= BFT_RST_RES_LVL + 16'h1;
		wst();
		timing(0, 1'b0);
		r1 <= 16'h0;
		bus(1'b1, BFT_REG_CTRL, 32'h10);
		block_in <= 1'b1;
		tk(2 * CYC);
		setc(1, BFT_RST_PH_LVL + 16'h1);
		tk((BF + 1) * CYC);
		`C("blk", 1'b1, blocked_out)
		`C("blk bf", 1'b0, breaker_failure_output)
		rc(BFT_REG_STATUS, 32'(BFT_ST_BLOCKED));
		block_in <= 1'b0;
		wst();
		tk(CYC);
		// block raised well before failure expiry
		block_in <= 1'b1;
		tk(2 * CYC);
		`C("late blk", 1'b0, start_out)
		`C("late rt", 1'b0, redundant_trip)
		block_in <= 1'b0;
		bus(1'b1, BFT_REG_CTRL, 32'h11);
		setc(2, BFT_RST_PH_LVL + 16'h40);
		tk((BF + 1) * CYC);
		`C("and held", 1'b0, breaker_failure_output)
		mid();
		trip_cmd <= 1'b1;
		timing(CYC / 2, 1'b1);
		trip_cmd <= 1'b0;
		tk(2 * CYC);
		`C("and rst", 1'b0, breaker_failure_output)
		setc(2, 16'h0);
		bus(1'b1, BFT_REG_CTRL, 32'h12);
		tk(2 * CYC);
		mid();
		trip_cmd <= 1'b1;
		timing(CYC / 2, 1'b1);
		setc(0, 16'h0100);
		trip_cmd <= 1'b0;
		tk(2 * CYC);
		`C("or hold", 1'b1, start_out)
		setc(0, 16'h0);
		tk(2 * CYC);
		`C("or rst", 1'b0, start_out)
		bus(1'b1, BFT_REG_CTRL, 32'h13);
		trip_cmd <= 1'b1;
		wst();
		trip_cmd <= 1'b0;
		tk(2 * CYC);
		`C("do rst", 1'b0, start_out)
		// second residual channel, then calculated residual
		bus(1'b1, BFT_REG_CTRL, 32'h18);
		r2 <= BFT_RST_RES_LVL + 16'h1;
		wst();
		bus(1'b1, BFT_REG_CTRL, 32'h1C);
		r2 <= 16'h0;
		tk(2 * CYC);
		`C("calc off", 1'b0, start_out)
		r3 <= BFT_RST_RES_LVL + 16'h1;
		wst();
		r3 <= 16'h0;
		tk(2 * CYC);
		`C("res rst", 1'b0, start_out)
		// one tick counted per program cycle
		bus(1'b0, BFT_REG_TICK, 32'h0);
		tcnt = d;
		tk(4 * CYC - 3);
		bus(1'b0, BFT_REG_TICK, 32'h0);
		`C("ticks", 32'h4, d - tcnt)
		wrap_up();
	end
	initial
	begin
		tk(40000);
		err_count++;
		wrap_up();
	end
endmodule // tb
bind breaker_failure_timer bft_checker chk (.mclk, .sys_rst, .avs_read,
	.avs_write, .avs_waitrequest, .redundant_trip, .breaker_failure_output,
	.start_out, .blocked_out);
`default_nettype wire
